// >>> spef_consts.vh
// Purpose: shared constants for the serial port error flag block
// Assumes: byte-wide register port, 4-bit register address
// Notes:   offsets are word indices on the plain register port
`ifndef SPEF_CONSTS_VH
`define SPEF_CONSTS_VH
// ==========================================================
// register offsets
`define SPEF_ADDR_CTRL      4'h0
`define SPEF_ADDR_DATA      4'h1
`define SPEF_ADDR_STAT      4'h2
`define SPEF_ADDR_IRQ_STAT  4'h3
`define SPEF_ADDR_IRQ_MASK  4'h4
`define SPEF_ADDR_AUX       4'h5
// ==========================================================
// control field positions and reset values
`define SPEF_BIT_WRITE_COLLISION_FLAG       7
`define SPEF_BIT_OVF        6
`define SPEF_BIT_EN         5
`define SPEF_BIT_CKP        4
`define SPEF_CTRL_RESET     8'h00
`define SPEF_BYTE_ZERO      8'h00
// ==========================================================
// mode field codes
`define SPEF_MODE_SLV_SS    4'h4
`define SPEF_MODE_SLV_NOSS  4'h5
// ==========================================================
// interrupt status bits
`define SPEF_IRQ_RX         0
`define SPEF_IRQ_WRITE_COLLISION_FLAG       1
`define SPEF_IRQ_OVF        2
`define SPEF_IRQ_BITS       3
// ==========================================================
// master clock half period in core cycles
`define SPEF_HALF_PERIOD    4
`define SPEF_LAST_BIT       3'h7
`endif

// >>> spef_sync.v
// Purpose: two-flop synchroniser with edge detect, one per bit
// Assumes: inputs are asynchronous to core_clk_i
// Notes:   edges come from the second and third flop only
module spef_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input  wire             core_clk_i,
  input  wire             resetn_i,
  // asynchronous inputs
  input  wire [WIDTH-1:0] async_i,
  // synchronised outputs
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] rise_o,
  output wire [WIDTH-1:0] fall_o
);

  genvar g;

  // ========================================================
  // per-bit synchroniser
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      reg meta_q;
      reg sync_q;
      reg prev_q;
      always @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end
        else
        begin
          meta_q <= async_i[g];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign level_o[g] = sync_q;
      assign rise_o[g]  = sync_q & ~prev_q;
      assign fall_o[g]  = ~sync_q & prev_q;
    end
  endgenerate

endmodule // spef_sync

// >>> spef_error_flags.v
// Purpose: serial port with write-collision and overflow flags
// Assumes: pins asynchronous; sck_i sampled by core_clk_i
// Notes:   i2c mode only shifts bytes; no start/stop handling
`include "spef_consts.vh"

module spef_error_flags #(
  parameter HALF_PERIOD = `SPEF_HALF_PERIOD
) (
  // clock and reset
  input  wire       core_clk_i,
  input  wire       resetn_i,
  // register port
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       we_i,
  input  wire       re_i,
  output wire [7:0] rdata_o,
  // serial pins
  input  wire       sck_i,
  input  wire       sdi_i,
  input  wire       ss_n_i,
  output wire       sck_o,
  output wire       sck_oe_o,
  output wire       sdo_o,
  // interrupt
  output wire       irq_o
);

  // ========================================================
  // state
  reg [7:0]                ctrl_q;
  reg [7:0]                ctrl_d;
  reg [7:0]                buf_q;
  reg                      bf_q;
  reg [7:0]                shreg_q;
  reg                      in_bit_q;
  reg [2:0]                cnt_q;
  reg                      busy_q;
  reg                      mck_q;
  reg [7:0]                div_q;
  reg                      sdo_q;
  reg                      sck_oe_q;
  reg                      i2c_tx_q;
  reg [`SPEF_IRQ_BITS-1:0] ist_q;
  reg [`SPEF_IRQ_BITS-1:0] ist_d;
  reg [`SPEF_IRQ_BITS-1:0] mask_q;
  reg                      irq_q;
  reg [7:0]                rdata_q;

  wire [2:0] s_level;
  wire [2:0] s_rise;
  wire [2:0] s_fall;

  // ========================================================
  // pin synchronisers: sck, sdi, ss_n
  spef_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    ({ss_n_i, sdi_i, sck_i}),
    .level_o    (s_level),
    .rise_o     (s_rise),
    .fall_o     (s_fall)
  );

  wire s_sdi = s_level[1];
  wire s_ssn = s_level[2];

  // ========================================================
  // mode decode
  wire [3:0] mode      = ctrl_q[3:0];
  wire       enable    = ctrl_q[`SPEF_BIT_EN];
  wire       clock_polarity_bit       = ctrl_q[`SPEF_BIT_CKP];
  wire       is_master = (mode[3:2] == 2'b00);
  wire       is_slave  = (mode == `SPEF_MODE_SLV_SS) |
                         (mode == `SPEF_MODE_SLV_NOSS);
  wire       is_i2c    = ~is_master & ~is_slave;
  wire       use_ss    = (mode == `SPEF_MODE_SLV_SS);
  wire       slv_sel   = ~use_ss | ~s_ssn;

  // ========================================================
  // edge selection
  // in master and slave modes the leading edge leaves the idle level set by ckp; i2c leads on the rise
  // limitation: half period under 3 cycles outruns the sdi synchroniser
  wire div_tick = busy_q & (div_q == HALF_PERIOD - 1);
  wire m_lead   = div_tick & (mck_q == clock_polarity_bit);
  wire m_trail  = div_tick & (mck_q != clock_polarity_bit);
  wire s_lead   = clock_polarity_bit ? s_fall[0] : s_rise[0];
  wire s_trail  = clock_polarity_bit ? s_rise[0] : s_fall[0];

  reg lead;
  reg trail;
  always @*
  begin
    lead  = 1'b0;
    trail = 1'b0;
    if (enable)
    begin
      if (is_master)
      begin
        lead  = m_lead;
        trail = m_trail;
      end
      else if (is_slave)
      begin
        lead  = slv_sel & s_lead;
        trail = slv_sel & s_trail;
      end
      else
      begin
        lead  = s_rise[0];
        trail = s_fall[0];
      end
    end
  end

  // ========================================================
  // byte events
  wire [7:0] byte_in = {shreg_q[6:0], in_bit_q};
  wire       done    = trail & (cnt_q == `SPEF_LAST_BIT);
  wire       busy    = is_master ? busy_q : (cnt_q != 3'h0);
  wire       wr_buf  = we_i & (addr_i == `SPEF_ADDR_DATA);
  wire       rd_buf  = re_i & (addr_i == `SPEF_ADDR_DATA);
  wire       wr_ctrl = we_i & (addr_i == `SPEF_ADDR_CTRL);
  wire       rd_ist  = re_i & (addr_i == `SPEF_ADDR_IRQ_STAT);
  wire       i2c_tx  = is_i2c & i2c_tx_q;
  wire       write_collision_flag_evt = enable & wr_buf & busy;
  // master never flags overflow; i2c transmit leaves the flag alone
  wire       ovf_evt = done & bf_q & ~is_master & ~i2c_tx;
  // overflow drops the shifted byte, buffer keeps old data
  wire       load    = done & ~i2c_tx & (~bf_q | is_master);
  wire       start_m = enable & wr_buf & is_master & ~busy_q;
  wire       load_s  = enable & wr_buf & ~is_master & ~busy;

  // ========================================================
  // shift engine
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shreg_q  <= `SPEF_BYTE_ZERO;
      in_bit_q <= 1'b0;
      cnt_q    <= 3'h0;
      busy_q   <= 1'b0;
      mck_q    <= 1'b0;
      div_q    <= 8'h00;
      sdo_q    <= 1'b0;
      sck_oe_q <= 1'b0;
    end
    else
    begin
      sck_oe_q <= enable & is_master;
      if (!enable)
      begin
        cnt_q  <= 3'h0;
        busy_q <= 1'b0;
        mck_q  <= clock_polarity_bit;
      end
      else
      begin
        if (start_m | load_s)
        begin
          shreg_q <= wdata_i;
          sdo_q   <= wdata_i[7];
        end
        if (start_m)
        begin
          busy_q <= 1'b1;
          cnt_q  <= 3'h0;
          div_q  <= 8'h00;
        end
        if (busy_q)
        begin
          div_q <= div_tick ? 8'h00 : div_q + 8'h01;
          if (div_tick)
            mck_q <= ~mck_q;
        end
        else
          mck_q <= clock_polarity_bit;
        if (lead)
          in_bit_q <= s_sdi;
        if (trail)
        begin
          shreg_q <= byte_in;
          sdo_q   <= shreg_q[6];
          cnt_q   <= cnt_q + 3'h1;
          if (done)
            busy_q <= 1'b0;
        end
        // deselect aborts a partial slave byte
        if (is_slave & use_ss & s_ssn)
          cnt_q <= 3'h0;
      end
    end
  end

  // ========================================================
  // buffer and buffer-full status
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      buf_q <= `SPEF_BYTE_ZERO;
      bf_q  <= 1'b0;
    end
    else
    begin
      if (load)
        buf_q <= byte_in;
      // a load in the read cycle keeps the buffer full
      if (load)
        bf_q <= 1'b1;
      else if (rd_buf)
        bf_q <= 1'b0;
    end
  end

  // ========================================================
  // control register with sticky flags
  always @*
  begin
    ctrl_d = wr_ctrl ? wdata_i : ctrl_q;
    // hardware set beats a software clear in the same cycle
    ctrl_d[`SPEF_BIT_WRITE_COLLISION_FLAG] = ctrl_d[`SPEF_BIT_WRITE_COLLISION_FLAG] | write_collision_flag_evt;
    ctrl_d[`SPEF_BIT_OVF]  = ctrl_d[`SPEF_BIT_OVF] | ovf_evt;
  end

  always @*
  begin
    ist_d = rd_ist ? {`SPEF_IRQ_BITS{1'b0}} : ist_q;
    ist_d[`SPEF_IRQ_RX]   = ist_d[`SPEF_IRQ_RX] | load;
    ist_d[`SPEF_IRQ_WRITE_COLLISION_FLAG] = ist_d[`SPEF_IRQ_WRITE_COLLISION_FLAG] | write_collision_flag_evt;
    ist_d[`SPEF_IRQ_OVF]  = ist_d[`SPEF_IRQ_OVF] | ovf_evt;
  end

  // ========================================================
  // registers and read port
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q   <= `SPEF_CTRL_RESET;
      ist_q    <= {`SPEF_IRQ_BITS{1'b0}};
      mask_q   <= {`SPEF_IRQ_BITS{1'b0}};
      i2c_tx_q <= 1'b0;
      irq_q    <= 1'b0;
      rdata_q  <= `SPEF_BYTE_ZERO;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ist_q  <= ist_d;
      irq_q  <= |(ist_q & mask_q);
      if (we_i & (addr_i == `SPEF_ADDR_IRQ_MASK))
        mask_q <= wdata_i[`SPEF_IRQ_BITS-1:0];
      if (we_i & (addr_i == `SPEF_ADDR_AUX))
        i2c_tx_q <= wdata_i[0];
      rdata_q <= `SPEF_BYTE_ZERO;
      if (re_i)
      begin
        case (addr_i)
          `SPEF_ADDR_CTRL:     rdata_q <= ctrl_q;
          `SPEF_ADDR_DATA:     rdata_q <= buf_q;
          `SPEF_ADDR_STAT:     rdata_q <= {6'h00, busy, bf_q};
          `SPEF_ADDR_IRQ_STAT: rdata_q <= {5'h00, ist_q};
          `SPEF_ADDR_IRQ_MASK: rdata_q <= {5'h00, mask_q};
          `SPEF_ADDR_AUX:      rdata_q <= {7'h00, i2c_tx_q};
          default:             rdata_q <= `SPEF_BYTE_ZERO;
        endcase
      end
    end
  end

  // ========================================================
  // outputs
  assign rdata_o  = rdata_q;
  assign sck_o    = mck_q;
  assign sck_oe_o = sck_oe_q;
  assign sdo_o    = sdo_q;
  assign irq_o    = irq_q;

endmodule // spef_error_flags

// >>> spef_error_flags_asserts.sv
// Purpose: port checks for the serial port error flags
// Assumes: control 0, data 1, mask 4
// Notes:   shadows follow software writes and control read data
module spef_flags_chk (
  // watched ports
  input wire logic       core_clk_i,
  input wire logic       resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       we_i,
  input wire logic       re_i,
  input wire logic [7:0] rdata_o,
  input wire logic       sck_oe_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // shadows
  logic [7:0] ctl_q;
  logic [2:0] msk_q;
  logic [1:0] st_q;
  logic [1:0] dwh_q;
  logic       rc_q;
  logic       cln_q;
  wire        wc  = we_i && addr_i == 4'h0;
  wire        dw  = we_i && addr_i == 4'h1;
  wire        mst = ctl_q[5] && ctl_q[3:0] < 4'h4;
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      ctl_q <= 8'h00;
      msk_q <= 3'h0;
      st_q  <= 2'h0;
      dwh_q <= 2'h0;
      rc_q  <= 1'b0;
      cln_q <= 1'b1;
    end
    else
    begin
      rc_q  <= re_i && addr_i == 4'h0;
      dwh_q <= {dwh_q[0], dw};
      if (we_i && addr_i == 4'h4)
        msk_q <= wdata_i[2:0];
      if (wc)
      begin
        ctl_q <= wdata_i;
        cln_q <= !wdata_i[6] && wdata_i[3:0] < 4'h4;
        st_q  <= wdata_i[7:6];
      end
      else
        st_q <= st_q | ({2{rc_q}} & rdata_o[7:6])
          | {dw & (|dwh_q) & mst, 1'b0};
    end
  // ==========
  // properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_rd_idle;
    !$past(re_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_ctl_rw;
    rc_q |-> rdata_o[5:0] == ctl_q[5:0];
  endproperty
  a_ctl_rw: assert property (p_ctl_rw) else $error("control bits");
  property p_flags;
    rc_q |-> (rdata_o[7:6] & st_q) == st_q;
  endproperty
  a_flags: assert property (p_flags) else $error("flag lost");
  property p_no_ovf;
    rc_q && cln_q |-> !rdata_o[6];
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("master overflow");
  property p_mask_rd;
    $past(re_i && addr_i == 4'h4) |-> rdata_o == {5'h00, msk_q};
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback");
  property p_irq_off;
    msk_q == 3'h0 && $past(msk_q) == 3'h0 |-> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked irq");
  property p_oe_on;
    sck_oe_o |-> mst || $past(mst);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("clock enable");
  property p_oe_off;
    !mst && !$past(mst) |-> !sck_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("clock not off");
endmodule // spef_flags_chk

bind spef_error_flags spef_flags_chk u_chk (.core_clk_i, .resetn_i,
  .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .sck_oe_o, .irq_o);

// >>> spef_peer_model.sv
// Purpose: serial peer for the error flag bench
// Assumes: clock polarity 0, leading edges rise
// Notes:   as slave rotates its reply; as master frames bytes
module spef_peer_model (
  // from the block
  input  wire logic dut_sck_i,
  input  wire logic dut_sdo_i,
  // to the block
  output logic      sck_o,
  output wire logic sdi_o,
  output logic      ss_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  logic       slv_q = 1'b0;
  logic       bit_q = 1'b0;
  // released line inverts, so a stale bit never passes
  assign sdi_o = slv_q ? (ss_n_o ? ~bit_q : bit_q) : tx_q[7];
  initial
  begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
  end
  always @(posedge dut_sck_i)
    rx_q <= {rx_q[6:0], dut_sdo_i};
  always @(negedge dut_sck_i)
    tx_q <= {tx_q[6:0], tx_q[7]};
  // clock stands low between frames
  task frame(input logic [7:0] b);
    slv_q = 1'b1;
    ss_n_o = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      bit_q = b[i];
      #40 sck_o = 1'b1;
      #40 sck_o = 1'b0;
    end
    #40 ss_n_o = 1'b1;
  endtask
endmodule // spef_peer_model

// >>> tb_top.sv
// Purpose: self-checking bench for the serial port error flags
// Assumes: HALF_PERIOD 4, peer clock period 80 ns
// Notes:   flags are seen through control reads
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // signals
  logic        clk;
  logic        rst_n;
  logic        we;
  logic        re;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  v;
  wire  [7:0]  rdata;
  wire         sck, sdi, ss_n, sck_m, sdo, irq;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // index, write value, read back
  logic [19:0] rows [0:4] = '{20'h0_25_25, 20'h4_FF_07,
    20'h6_5A_00, 20'h2_FF_00, 20'h4_07_07};
  spef_error_flags #(.HALF_PERIOD(4)) dut (.core_clk_i(clk),
    .resetn_i(rst_n), .addr_i(addr), .wdata_i(wdata), .we_i(we),
    .re_i(re), .rdata_o(rdata), .sck_i(sck), .sdi_i(sdi), .ss_n_i(ss_n),
    .sck_o(sck_m), .sck_oe_o(), .sdo_o(sdo), .irq_o(irq));
  spef_peer_model p (.dut_sck_i(sck_m), .dut_sdo_i(sdo), .sck_o(sck),
    .sdi_o(sdi), .ss_n_o(ss_n));
  // ==========
  // tasks
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input string n);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    v = rdata;
    if (n != "")
      chk(n, e, v);
    @(posedge clk);
  endtask
  task wait_idle;
    v = 8'h02;
    for (int n = 0; n < 99 && v[1]; n++)
      rd(4'h2, 8'h00, "");
    chk("busy", 8'h00, {7'h00, v[1]});
  endtask
  task chk_irq(input logic e);
    @(negedge clk);
    chk("irq", {7'h00, e}, {7'h00, irq});
    @(posedge clk);
  endtask
  // realign to the core clock after a frame
  task xfer(input logic [7:0] b);
    p.frame(b);
    repeat (5) @(posedge clk);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========
  // clock, watchdog, tests
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100us;
    n_mismatch++;
    end_sim;
  end
  initial
  begin
    rst_n = 1'b0;
    {we, re, addr, wdata} = 14'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h00, "ctl_rst");
    foreach (rows[i])
    begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], rows[i][7:0], "row");
    end
    wr(4'h0, 8'h20);
    p.tx_q = 8'h3C;
    wr(4'h1, 8'hA5);
    wr(4'h1, 8'h11);
    wait_idle;
    chk("peer_rx", 8'hA5, p.rx_q);
    rd(4'h2, 8'h01, "bf_set");
    p.tx_q = 8'h81;
    wr(4'h1, 8'h0F);
    wait_idle;
    rd(4'h0, 8'hA0, "ctl_m");
    rd(4'h1, 8'h81, "buf_m");
    rd(4'h2, 8'h00, "bf_clr");
    wr(4'h0, 8'h20);
    rd(4'h0, 8'h20, "ctl_clr");
    chk_irq(1'b1);
    rd(4'h3, 8'h03, "irq_m");
    chk_irq(1'b0);
    wr(4'h0, 8'h24);
    xfer(8'h96);
    rd(4'h1, 8'h96, "buf_s");
    xfer(8'h11);
    xfer(8'h22);
    rd(4'h0, 8'h64, "ctl_ovf");
    rd(4'h1, 8'h11, "buf_keep");
    rd(4'h3, 8'h05, "irq_s");
    fork
      xfer(8'h33);
      begin
        repeat (30) @(posedge clk);
        wr(4'h1, 8'h77);
      end
    join
    rd(4'h0, 8'hE4, "ctl_write_collision_flag");
    rd(4'h1, 8'h33, "buf_s2");
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h28);
    xfer(8'h5A);
    xfer(8'hC3);
    chk_irq(1'b0);
    rd(4'h0, 8'h68, "ctl_i2c");
    rd(4'h1, 8'h5A, "buf_i2c");
    rd(4'h3, 8'h07, "irq_i");
    // reset in mid-run with the overflow flag still set
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h00, "ctl_rst2");
    // i2c transmit: full buffer neither flags nor reloads
    wr(4'h0, 8'h28);
    xfer(8'h3C);
    wr(4'h5, 8'h01);
    xfer(8'hC3);
    rd(4'h0, 8'h28, "ctl_i2c_tx");
    rd(4'h1, 8'h3C, "buf_i2c_tx");
    // master clock idles at the polarity bit
    wr(4'h0, 8'h30);
    @(negedge clk);
    chk("sck_idle", 8'h01, {7'h00, sck_m});
    @(posedge clk);
    end_sim;
  end
endmodule // tb_top
